// [trs_pkg.sv]
package trs_pkg;

    // ========================================
    // register map (byte addresses, one word each)
    localparam logic [11:0] ctrl_addr     = 12'h000;
    localparam logic [11:0] status_addr   = 12'h004;
    localparam logic [11:0] ident_addr    = 12'h008;
    localparam logic [11:0] blk_len_addr  = 12'h00c;

    // ========================================
    // field positions
    localparam int run_bit        = 0;
    localparam int hw_mode_bit    = 1;
    localparam int st_running_bit = 0;
    localparam int st_sync_out_bit = 1;
    localparam int st_aligned_bit = 2;
    localparam int rev_lsb        = 0;
    localparam int part_lsb       = 4;

    // ========================================
    // reset values and timing
    localparam logic [31:0] ctrl_reset    = 32'h0000_0000;
    localparam int          sync_in_min_clocks = 3;
    localparam int          subframe_clocks    = 64;
    localparam int          block_subframes    = 384;

    // ========================================
    // types
    typedef enum logic [2:0] {
        st_low_power = 3'b001,
        st_wait_run  = 3'b010,
        st_active    = 3'b100
    } trs_state_type;

    typedef struct packed {
        logic       run;
        logic       hw_mode;
    } trs_ctrl_type;

    typedef struct packed {
        logic       line_driver_pos;
        logic       line_driver_neg;
        logic       tx_enable;
    } trs_line_type;

endpackage

// [trs_top.sv]
// Overview of operation
// RULE1: reset low holds low power and clears every register and port state.
// RULE2: transmit outputs stay disabled while reset is low.
// RULE3: software mode: after reset the register port works; device waits idle.
// RULE4: host loads settings, then writes run one; device then starts transmitting.
// RULE5: pin mode: device starts running on reset release with no write.
// RULE6: a readable register holds a four-bit part identification code.
// RULE7: a readable register holds a four-bit silicon revision code.
// RULE8: all grouped transmitters share master clock, reset and block sync.
// RULE9: block sync aligns channel status block starts across transmitters.
// RULE10: exactly one device drives block sync; the others receive it.
// RULE11: with external sync logic every device receives, none drives.
// RULE12: input high three clocks restarts block; output high only first subframe.
// RULE13: both line driver outputs are pulled low while in reset.
// RULE14: board strap high makes block sync an output, low an input.
// RULE15: run bit reads zero after reset, so device idles until set.
//
// Added by the designer: the APB slave port and the register offsets.
module trs_top #(
    parameter logic [3:0] part_id_code  = 4'h5,  // arbitrary value
    parameter logic [3:0] revision_code = 4'h1,  // arbitrary value
    parameter int         subframe_len  = trs_pkg::subframe_clocks,
    parameter int         block_len     = trs_pkg::block_subframes
) (
    input  wire logic        pclk,                         // master clock in
    input  wire logic        presetn,                      // async reset, active low
    input  wire logic        psel,                         // apb select
    input  wire logic        penable,                      // apb enable
    input  wire logic        pwrite,                       // apb direction
    input  wire logic [11:0] paddr,                        // apb byte address
    input  wire logic [31:0] pwdata,                       // apb write data
    output logic [31:0]      prdata,                       // apb read data
    output logic             pready,                       // apb ready
    output logic             pslverr,                      // apb error
    input  wire logic        hw_mode_pin,                  // high: pin-configured operation
    input  wire logic        block_sync_direction_strap,   // high: sync is output
    input  wire logic        block_boundary_sync_i,        // sync pin input
    output logic             block_boundary_sync_o,        // sync pin output
    output logic             block_boundary_sync_oe,       // sync pin output enable
    input  wire logic        tx_data,                      // encoded bit stream to send
    output logic             line_driver_pos,              // line driver, positive
    output logic             line_driver_neg,              // line driver, negative
    output logic             low_power,                    // low-power state indicator
    output logic             subframe_start                // pulse at each subframe start
);

    // ========================================
    // usage notes
    // the register port answers in the same access cycle; pready is tied high.
    // read data is loaded at the setup edge, so it stands through the access phase.
    // an unmapped address raises pslverr in the access phase; writes there are dropped.
    // writes to the status, ident and length words are ignored without an error.
    // the direction strap is caught once, in the first cycle after reset release;
    // moving the strap later has no effect until the next reset.
    // in pin mode the run bit is ignored and the block runs two edges after release.
    // in software mode clearing the run bit returns to the idle state; the timebase
    // restarts from subframe zero on the next run.
    // a sync input shorter than the qualifying length is ignored entirely.
    // a qualified sync input takes effect at the next subframe end, never mid-subframe,
    // so a partly sent subframe is always finished.
    // a sync input that stays high restarts the block again at every subframe end while it stays high.
    // the sync output is registered from the next-state value so that it rises in the
    // same cycle as subframe_start of the first subframe of every block.
    // a device strapped as sync output ignores its sync input altogether.
    // the line drivers are registered, one cycle behind tx_data.
    // low_power is decoded from the state register and has no extra latency.
    // the aligned status bit records that a peer has ever steered the block start.

    // ========================================
    // elaboration checks: refuse sizes the counters cannot serve
    if (subframe_len < 4) begin : g_bad_subframe
        $error("trs_top: subframe_len below 4");
    end
    if (block_len < 2) begin : g_bad_block
        $error("trs_top: block_len below 2");
    end
    if (trs_pkg::sync_in_min_clocks < 2 || trs_pkg::sync_in_min_clocks > 4) begin : g_bad_sync
        $error("trs_top: sync qualifier length outside 2 to 4");
    end

    localparam int sf_w  = $clog2(subframe_len);
    localparam int blk_w = $clog2(block_len);
    localparam logic [1:0] sync_cnt_max = 2'(trs_pkg::sync_in_min_clocks - 1);

    // ========================================
    // state
    trs_pkg::trs_ctrl_type  ctrl_q;
    trs_pkg::trs_state_type state_q, state_d;
    logic                   strap_q;
    logic [sf_w-1:0]        sf_cnt_q;
    logic [blk_w-1:0]       blk_cnt_q;
    logic [1:0]             sync_cnt_q;
    logic                   restart_pend_q;
    logic                   aligned_q;
    logic                   running;
    logic                   sf_end;
    logic                   wr_en;
    logic                   rd_en;
    logic                   addr_ok;
    logic                   blk_last;
    logic                   sync_o_d;

    // ========================================
    // apb slave: zero wait states, error on unmapped address
    // no register needs more than one cycle, so pready never drops
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !pwrite;
    assign pready  = 1'b1;
    assign addr_ok = (paddr == trs_pkg::ctrl_addr) || (paddr == trs_pkg::status_addr) ||
                     (paddr == trs_pkg::ident_addr) || (paddr == trs_pkg::blk_len_addr);
    assign pslverr = psel && penable && !addr_ok;

    // control register, cleared by reset
    // only the run and spare bits exist; the rest of the word is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= trs_pkg::trs_ctrl_type'(trs_pkg::ctrl_reset[1:0]);  // RULE1 RULE15
        end else if (wr_en && paddr == trs_pkg::ctrl_addr) begin
            ctrl_q.run     <= pwdata[trs_pkg::run_bit];  // RULE4
            ctrl_q.hw_mode <= pwdata[trs_pkg::hw_mode_bit];
        end
    end

    // read data register
    // loaded at the setup edge so the value is settled by the access edge
    // the ident word packs the revision below the part code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;  // RULE1
        end else if (rd_en && !penable) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
                trs_pkg::ctrl_addr: begin
                    prdata[trs_pkg::run_bit]     <= ctrl_q.run;
                    prdata[trs_pkg::hw_mode_bit] <= ctrl_q.hw_mode;
                end
                trs_pkg::status_addr: begin
                    prdata[trs_pkg::st_running_bit]  <= running;
                    prdata[trs_pkg::st_sync_out_bit] <= strap_q;
                    prdata[trs_pkg::st_aligned_bit]  <= aligned_q;
                end
                trs_pkg::ident_addr: begin
                    prdata[trs_pkg::rev_lsb +: 4]  <= revision_code;  // RULE7
                    prdata[trs_pkg::part_lsb +: 4] <= part_id_code;   // RULE6
                end
                trs_pkg::blk_len_addr: begin
                    prdata <= 32'(block_len);
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ========================================
    // power state machine
    // the low-power state lasts one edge after release, which gives
    // the direction strap its capture slot before anything runs
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            trs_pkg::st_low_power: begin
                state_d = trs_pkg::st_wait_run;  // RULE3
            end
            trs_pkg::st_wait_run: begin
                if (hw_mode_pin || ctrl_q.run)
                    state_d = trs_pkg::st_active;  // RULE4 RULE5
            end
            trs_pkg::st_active: begin
                if (!hw_mode_pin && !ctrl_q.run)
                    state_d = trs_pkg::st_wait_run;
            end
            default: begin
                state_d = trs_pkg::st_low_power;
            end
        endcase
    end

    // state register
    // asynchronous clear so the outputs go quiet without a clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state_q <= trs_pkg::st_low_power;  // RULE1
        else
            state_q <= state_d;
    end

    assign running   = (state_q == trs_pkg::st_active);
    assign low_power = !running;

    // strap caught after reset release
    // late strap changes are ignored: the role must not flip while peers listen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            strap_q <= 1'b0;
        else if (state_q == trs_pkg::st_low_power)
            strap_q <= block_sync_direction_strap;  // RULE14
    end

    // ========================================
    // sync input qualifier: high for three clocks
    // counter saturates, so a long high level keeps requesting a restart at every subframe end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_cnt_q <= 2'h0;
        end else if (strap_q || !block_boundary_sync_i) begin
            sync_cnt_q <= 2'h0;
        end else if (sync_cnt_q != sync_cnt_max) begin
            sync_cnt_q <= sync_cnt_q + 2'h1;  // RULE12
        end
    end

    // pending block restart, set wins over clear
    // a pulse qualified on a subframe end is kept for the next end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            restart_pend_q <= 1'b0;
        else if (!strap_q && block_boundary_sync_i && sync_cnt_q == sync_cnt_max)
            restart_pend_q <= 1'b1;  // RULE12 RULE9
        else if (sf_end)
            restart_pend_q <= 1'b0;
    end

    // ========================================
    // subframe and block timebase
    // the subframe counter is held at zero while idle so a run starts on a boundary
    assign sf_end         = running && (sf_cnt_q == sf_w'(subframe_len - 1));
    assign subframe_start = running && (sf_cnt_q == '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sf_cnt_q <= '0;
        else if (!running || sf_end)
            sf_cnt_q <= '0;
        else
            sf_cnt_q <= sf_cnt_q + 1'b1;
    end

    // block counter, restarted by qualified sync input
    // aligned stays set until reset to record that a peer steered the block
    assign blk_last = (blk_cnt_q == blk_w'(block_len - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_cnt_q <= '0;
            aligned_q <= 1'b0;
        end else if (!running) begin
            blk_cnt_q <= '0;
        end else if (sf_end) begin
            if (restart_pend_q) begin
                blk_cnt_q <= '0;  // RULE9 RULE12
                aligned_q <= 1'b1;
            end else if (blk_last) begin
                blk_cnt_q <= '0;
            end else begin
                blk_cnt_q <= blk_cnt_q + 1'b1;
            end
        end
    end

    // sync output next value: high for every cycle of the block's first subframe,
    // taken from the next state so that it lines up with subframe_start
    always_comb begin
        sync_o_d = 1'b0;
        if (strap_q && state_d == trs_pkg::st_active) begin
            if (sf_end)
                sync_o_d = restart_pend_q || blk_last;  // RULE12
            else
                sync_o_d = (blk_cnt_q == '0);  // RULE12
        end
    end

    // sync output driven only when strapped as master
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_boundary_sync_o  <= 1'b0;
            block_boundary_sync_oe <= 1'b0;
        end else begin
            block_boundary_sync_oe <= strap_q;  // RULE10 RULE11
            block_boundary_sync_o  <= sync_o_d;  // RULE12
        end
    end

    // ========================================
    // line drivers: low in reset and low power
    // both legs low while idle keeps the output transformer free of standing current
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_driver_pos <= 1'b0;  // RULE2 RULE13
            line_driver_neg <= 1'b0;  // RULE13
        end else if (running) begin
            line_driver_pos <= tx_data;
            line_driver_neg <= !tx_data;
        end else begin
            line_driver_pos <= 1'b0;  // RULE2
            line_driver_neg <= 1'b0;
        end
    end

endmodule

// [trs_sync_peer.sv]
// ====================
// peer transmitter that drives the shared block sync line
module trs_sync_peer (
    input  wire logic       pclk, // shared master clock
    input  wire logic       fire, // start one pulse
    input  wire logic [3:0] hold, // pulse length in clocks
    output logic            sync  // block sync to the receiving device
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt_q = 4'h0;
    // one driver only, counts the pulse down on the shared clock
    always_ff @(posedge pclk) begin
        if (fire) cnt_q <= hold;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
    assign sync = (cnt_q != 4'h0);
endmodule

// [trs_top_props.sv]
// ====================
// port checker for the reset and start-up block
module trs_props #(
    parameter logic [3:0] part_id_code  = 4'h1, // part code
    parameter logic [3:0] revision_code = 4'h1  // revision code
) (
    input wire logic        pclk,                       // clock
    input wire logic        presetn,                    // reset, low
    input wire logic        psel,                       // select
    input wire logic        penable,                    // enable
    input wire logic        pwrite,                     // direction
    input wire logic [11:0] paddr,                      // address
    input wire logic [31:0] pwdata,                     // write data
    input wire logic [31:0] prdata,                     // read data
    input wire logic        pready,                     // ready
    input wire logic        pslverr,                    // error
    input wire logic        hw_mode_pin,                // pin mode
    input wire logic        block_sync_direction_strap, // sync direction
    input wire logic        block_boundary_sync_o,      // sync out
    input wire logic        block_boundary_sync_oe,     // sync enable
    input wire logic        tx_data,                    // bit in
    input wire logic        line_driver_pos,            // driver pos
    input wire logic        line_driver_neg,            // driver neg
    input wire logic        low_power,                  // idle flag
    input wire logic        subframe_start              // subframe pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic mapped;
    // access phase and address decode
    assign acc = psel && penable;
    assign mapped = paddr inside {trs_pkg::ctrl_addr, trs_pkg::status_addr,
                                  trs_pkg::ident_addr, trs_pkg::blk_len_addr};
    a_ready_now: assert property (acc |-> pready)
        else $error("access not answered");
    a_unmapped_err: assert property (acc |-> pslverr == !mapped)
        else $error("error flag wrong for address");
    a_ident_value: assert property (acc && !pwrite && paddr == trs_pkg::ident_addr
        |-> prdata[7:0] == {part_id_code, revision_code}) else $error("ident wrong");
    a_idle_after_rst: assert property (!hw_mode_pin && !$past(presetn) |-> low_power[*3])
        else $error("left low power without run");
    a_run_wakes: assert property (acc && pwrite && paddr == trs_pkg::ctrl_addr
        && pwdata[trs_pkg::run_bit] && !hw_mode_pin |-> ##[1:3] !low_power)
        else $error("run write did not wake");
    a_pin_autorun: assert property (hw_mode_pin && !$past(presetn) |-> ##[1:3] !low_power)
        else $error("pin mode did not start");
    a_idle_quiet: assert property (low_power && $past(low_power)
        |-> !line_driver_pos && !line_driver_neg) else $error("driver active in low power");
    a_drive_follow: assert property (!low_power && !$past(low_power)
        |-> line_driver_pos == $past(tx_data) && line_driver_neg != $past(tx_data))
        else $error("drivers do not follow data");
    a_slave_quiet: assert property (!block_boundary_sync_oe |-> !block_boundary_sync_o)
        else $error("sync driven as input");
    a_strap_held: assert property ($past(presetn, 2)
        |-> block_boundary_sync_oe == block_sync_direction_strap) else $error("strap wrong");
    a_sync_gap: assert property ($fell(block_boundary_sync_o) |-> !block_boundary_sync_o[*8])
        else $error("sync high again too soon");
    a_sf_single: assert property (subframe_start |=> !subframe_start)
        else $error("subframe start longer than one cycle");
    a_sync_on_start: assert property ($rose(block_boundary_sync_o) |-> subframe_start)
        else $error("sync out not on a subframe start");
endmodule
bind trs_top trs_props #(.part_id_code(part_id_code), .revision_code(revision_code)) i_trs_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_mode_pin(hw_mode_pin), .block_sync_direction_strap(block_sync_direction_strap),
    .block_boundary_sync_o(block_boundary_sync_o),
    .block_boundary_sync_oe(block_boundary_sync_oe), .tx_data(tx_data),
    .line_driver_pos(line_driver_pos), .line_driver_neg(line_driver_neg),
    .low_power(low_power), .subframe_start(subframe_start));

// [transmitter_reset_startup_sync_test.sv]
// ====================
// bench for reset, start-up and block sync
module transmitter_reset_startup_sync_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] part_id = 4'h5; // arbitrary value
    localparam logic [3:0] rev_id  = 4'h1; // arbitrary value
    logic        pclk, presetn, psel, penable, pwrite, hw_mode, strap, tx_data, fire;
    logic        pready, pslverr, sync_o, sync_oe, peer_sync, pos, neg, low_power;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, w;
    logic [3:0]  hold;
    logic [32:0] exp_q[$];
    int          fail_count, num_checks, h;
    trs_top #(.part_id_code(part_id), .revision_code(rev_id), .subframe_len(8), .block_len(4))
        i_trs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_mode_pin(hw_mode), .block_sync_direction_strap(strap),
        .block_boundary_sync_i(sync_oe ? sync_o : peer_sync), .block_boundary_sync_o(sync_o),
        .block_boundary_sync_oe(sync_oe), .tx_data(tx_data), .line_driver_pos(pos),
        .line_driver_neg(neg), .low_power(low_power), .subframe_start());
    trs_sync_peer i_trs_sync_peer (.pclk(pclk), .fire(fire), .hold(hold), .sync(peer_sync));
    // clock and random line data
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) tx_data <= 1'($urandom);
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // bounded wait on low power (sel 0) or sync out (sel 1)
    task automatic wait_on(input logic sel, input logic v);
        int n;
        n = 0;
        while ((sel ? sync_o : low_power) !== v && n < 60) begin
            @(posedge pclk);
            n++;
        end
        chk({32'h0, sel ? sync_o : low_power}, {32'h0, v});
        if (n >= 60) final_report();
    endtask
    // one apb transfer; a read notes its expected answer
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        if (!wr) exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(33'h1, 33'h0);
            final_report();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic pulse(input logic [3:0] len);
        fire <= 1'b1;
        hold <= len;
        @(posedge pclk);
        fire <= 1'b0;
        repeat (20) @(posedge pclk);
    endtask
    // read answers compared in the order they were issued
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) chk(33'h1, 33'h0);
            else chk({pslverr, prdata}, exp_q.pop_front());
        end
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, hw_mode, fire, tx_data} = 7'h0;
        {paddr, pwdata, hold, strap} = {12'h0, 32'h0, 4'h0, 1'b1};
        fail_count = 0;
        num_checks = 0;
        void'($urandom(32'hfa65e093));
        repeat (2) @(posedge pclk);
        chk({29'h0, low_power, pos, neg, sync_oe}, 33'h8);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, trs_pkg::ctrl_addr, 32'h0, {1'b0, trs_pkg::ctrl_reset});
        apb(1'b0, trs_pkg::ident_addr, 32'h0, {25'h0, part_id, rev_id});
        apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h010, 32'h1, 33'h0);
        w = {30'h0, 1'($urandom), 1'b0};
        apb(1'b1, trs_pkg::ctrl_addr, w, 33'h0);
        apb(1'b0, trs_pkg::ctrl_addr, 32'h0, {1'b0, w});
        chk({32'h0, low_power}, 33'h1);
        apb(1'b1, trs_pkg::ctrl_addr, w | 32'h1, 33'h0);
        wait_on(1'b0, 1'b0);
        apb(1'b0, trs_pkg::status_addr, 32'h0, {1'b0, 32'h3});
        wait_on(1'b1, 1'b0);
        wait_on(1'b1, 1'b1);
        h = 0;
        repeat (32) begin
            h += int'(sync_o);
            @(posedge pclk);
        end
        chk({1'b0, 32'(h)}, 33'h8);
        chk({32'h0, sync_o}, 33'h1);
        presetn <= 1'b0;
        hw_mode <= 1'b1;
        strap <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({29'h0, low_power, pos, neg, sync_oe}, 33'h8);
        presetn <= 1'b1;
        wait_on(1'b0, 1'b0);
        apb(1'b0, trs_pkg::ctrl_addr, 32'h0, 33'h0);
        pulse(4'h2);
        apb(1'b0, trs_pkg::status_addr, 32'h0, {1'b0, 32'h1});
        pulse(4'h3);
        apb(1'b0, trs_pkg::status_addr, 32'h0, {1'b0, 32'h5});
        final_report();
    end
endmodule
